// ==== bbe_checker.sv ====
`default_nettype none
module bbe_checker
    import branch_bitset_pkg::*;
(
    input wire logic CLK_SYS_IN,
    input wire logic RST_IN,
    input wire logic INSTR_VALID_IN,
    input wire logic FLUSH_OUT,
    input wire logic MEM_RD_OUT,
    input wire logic MEM_WR_OUT,
    input wire logic PC_LOAD_OUT,
    input wire logic STATUS_WR_OUT,
    input wire logic [15:0] INSTR_IN,
    input wire logic [1:0] PHASE_OUT
);
    default clocking @(posedge CLK_SYS_IN); endclocking
    default disable iff (RST_IN);
    wire take = PHASE_OUT == PH_Q1 && INSTR_VALID_IN && !FLUSH_OUT;
    sequence s_rmw; MEM_RD_OUT ##2 MEM_WR_OUT; endsequence
    sequence s_jmp; !PC_LOAD_OUT [*2] ##1 PC_LOAD_OUT ##1 FLUSH_OUT [*4]; endsequence
    property p_set; take && INSTR_IN[15:12] == OPC_BITSET_NIB |=> s_rmw; endproperty
    property p_jmp; take && INSTR_IN[15:11] == {OPC_JUMP_NIB, 1'b0} |=> s_jmp; endproperty
    property p_ld; PC_LOAD_OUT |-> PHASE_OUT == PH_Q4; endproperty
    property p_st; !STATUS_WR_OUT; endproperty
    a_set: assert property (p_set) else $error("bit set late");
    a_jmp: assert property (p_jmp) else $error("jump late");
    a_ld: assert property (p_ld) else $error("pc load phase");
    a_st: assert property (p_st) else $error("status written");
    property p_fl; FLUSH_OUT |-> !PC_LOAD_OUT && !MEM_RD_OUT && !MEM_WR_OUT; endproperty
    property p_rd; MEM_RD_OUT |-> PHASE_OUT == PH_Q2; endproperty
    a_fl: assert property (p_fl) else $error("work in flush cycle");
    a_rd: assert property (p_rd) else $error("read phase");
endmodule : bbe_checker
`default_nettype wire

// ==== branch_and_bit_set_exec_test.sv ====
`default_nettype none
module branch_and_bit_set_exec_test import branch_bitset_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic CLK_SYS_IN = 0, RST_IN = 1, INSTR_VALID_IN = 0, EXT_SET_EN_IN = 0;
    logic [15:0] INSTR_IN = 16'h0000;
    logic [PC_W-1:0] PC_INCR_IN = 21'h000000, PC_NEW_OUT;
    logic [3:0] BANK_POINTER_REG_IN = 4'h3;
    logic [11:0] INDEX_BASE_IN = 12'hFF0, MEM_ADDR_OUT;
    logic [7:0] MEM_RDATA_IN = 8'h00, MEM_WDATA_OUT;
    logic [1:0] PHASE_OUT;
    logic MEM_RD_OUT, MEM_WR_OUT, PC_LOAD_OUT, FLUSH_OUT, STATUS_WR_OUT;
    int fails = 0, compares = 0;
    branch_bitset_exec dut (
        .CLK_SYS_IN(CLK_SYS_IN),
        .RST_IN(RST_IN),
        .INSTR_IN(INSTR_IN),
        .INSTR_VALID_IN(INSTR_VALID_IN),
        .PC_INCR_IN(PC_INCR_IN),
        .BANK_POINTER_REG_IN(BANK_POINTER_REG_IN),
        .INDEX_BASE_IN(INDEX_BASE_IN),
        .EXT_SET_EN_IN(EXT_SET_EN_IN),
        .MEM_RDATA_IN(MEM_RDATA_IN),
        .PHASE_OUT(PHASE_OUT),
        .MEM_ADDR_OUT(MEM_ADDR_OUT),
        .MEM_RD_OUT(MEM_RD_OUT),
        .MEM_WR_OUT(MEM_WR_OUT),
        .MEM_WDATA_OUT(MEM_WDATA_OUT),
        .PC_LOAD_OUT(PC_LOAD_OUT),
        .PC_NEW_OUT(PC_NEW_OUT),
        .FLUSH_OUT(FLUSH_OUT),
        .STATUS_WR_OUT(STATUS_WR_OUT)
    );
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin fails++; \
    $display("BAD %s exp %0h got %0h", n, e, g); end end
    initial forever #12.5 CLK_SYS_IN = ~CLK_SYS_IN;
    task stop_test;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : stop_test
    // Every wait is bounded so a silent design cannot hang the run.
    task automatic await(ref logic s);
        for (int k = 0; s !== 1'b1; k++)
        begin
            if (k > 9)
            begin
                fails++;
                stop_test();
            end
            @(posedge CLK_SYS_IN);
            #1;
        end
    endtask : await
    task automatic do_set(input logic [15:0] ins, input logic [11:0] ea, input logic [7:0] rd, wd);
        @(posedge CLK_SYS_IN);
        INSTR_IN <= ins;
        INSTR_VALID_IN <= 1'b1;
        MEM_RDATA_IN <= rd;
        await(MEM_RD_OUT);
        `CHK("addr", ea, MEM_ADDR_OUT)
        @(posedge CLK_SYS_IN);
        INSTR_VALID_IN <= 1'b0;
        MEM_RDATA_IN <= ~rd;
        @(posedge CLK_SYS_IN);
        #1;
        `CHK("wdata", wd, MEM_WDATA_OUT)
        `CHK("wr", 1'h1, MEM_WR_OUT)
        `CHK("status", 1'h0, STATUS_WR_OUT)
    endtask : do_set
    task automatic do_jmp(input logic [10:0] o, input logic [PC_W-1:0] pc);
        @(posedge CLK_SYS_IN);
        INSTR_IN <= {OPC_JUMP_NIB, 1'b0, o};
        INSTR_VALID_IN <= 1'b1;
        PC_INCR_IN <= pc;
        await(PC_LOAD_OUT);
        @(posedge CLK_SYS_IN);
        #1;
        `CHK("pc", pc + {{9{o[10]}}, o, 1'b0}, PC_NEW_OUT)
        `CHK("flush", 1'h1, FLUSH_OUT)
        // The jump stays offered into the flush cycle, which must refuse it.
        @(posedge CLK_SYS_IN);
        INSTR_VALID_IN <= 1'b0;
        repeat (2) @(posedge CLK_SYS_IN);
        #1;
        `CHK("reload", 1'b0, PC_LOAD_OUT)
    endtask : do_jmp
    task t_bitset;
        do_set(16'h8F12, 12'h312, 8'h0A, 8'h8A);
        do_set(16'h8070, 12'hF70, 8'hFE, 8'hFF);
        EXT_SET_EN_IN <= 1'b1;
        do_set(16'h845F, 12'h04F, 8'h00, 8'h04);
        do_set(16'h8060, 12'hF60, 8'h01, 8'h01);
        $display("bitset done");
    endtask : t_bitset
    task t_jump;
        do_jmp(11'h400, 21'h000100);
        do_jmp(11'h3FF, 21'h1FFFFE);
        // A set fifth bit makes the word something other than a jump.
        @(posedge CLK_SYS_IN);
        INSTR_IN <= 16'hD800;
        INSTR_VALID_IN <= 1'h1;
        repeat (4) @(posedge CLK_SYS_IN);
        INSTR_VALID_IN <= 1'h0;
        #1;
        `CHK("nojump", 1'h0, PC_LOAD_OUT)
        $display("jump done");
    endtask : t_jump
    initial
    begin
        repeat (2) @(posedge CLK_SYS_IN);
        RST_IN <= 1'b0;
        t_bitset();
        t_jump();
        stop_test();
    end
endmodule : branch_and_bit_set_exec_test
bind branch_bitset_exec bbe_checker chk (
    .CLK_SYS_IN(CLK_SYS_IN),
    .RST_IN(RST_IN),
    .INSTR_VALID_IN(INSTR_VALID_IN),
    .FLUSH_OUT(FLUSH_OUT),
    .MEM_RD_OUT(MEM_RD_OUT),
    .MEM_WR_OUT(MEM_WR_OUT),
    .PC_LOAD_OUT(PC_LOAD_OUT),
    .STATUS_WR_OUT(STATUS_WR_OUT),
    .INSTR_IN(INSTR_IN),
    .PHASE_OUT(PHASE_OUT)
);
`default_nettype wire

// ==== branch_bitset_exec.sv ====
`default_nettype none
module branch_bitset_exec
    import branch_bitset_pkg::*;
(
    input wire logic CLK_SYS_IN,
    input wire logic RST_IN,
    input wire logic [15:0] INSTR_IN,
    input wire logic INSTR_VALID_IN,
    input wire logic [PC_W-1:0] PC_INCR_IN,
    input wire logic [3:0] BANK_POINTER_REG_IN,
    input wire logic [11:0] INDEX_BASE_IN,
    input wire logic EXT_SET_EN_IN,
    input wire logic [7:0] MEM_RDATA_IN,
    output logic [1:0] PHASE_OUT,
    output logic [11:0] MEM_ADDR_OUT,
    output logic MEM_RD_OUT,
    output logic MEM_WR_OUT,
    output logic [7:0] MEM_WDATA_OUT,
    output logic PC_LOAD_OUT,
    output logic [PC_W-1:0] PC_NEW_OUT,
    output logic FLUSH_OUT,
    output logic STATUS_WR_OUT
);
    // ----------------------------------------------------------------
    // Phase counter and instruction decode
    // ----------------------------------------------------------------
    logic [1:0] phase_r;
    cyc_t cyc_r;
    logic [15:0] instr_r;
    logic [7:0] data_r;
    logic [11:0] addr_r;
    logic bit_op_r;

    wire is_jump = (INSTR_IN[15:12] == OPC_JUMP_NIB) && !INSTR_IN[11];
    wire is_bitset = (INSTR_IN[15:12] == OPC_BITSET_NIB);
    wire start = INSTR_VALID_IN && (phase_r == PH_Q1) && (cyc_r == CYC_EXEC);
    wire acc_bit = INSTR_IN[8];
    wire [7:0] file_adr = INSTR_IN[7:0];

    // Address formation; the access bank splits low RAM from the top SFR bank.
    wire use_index = !acc_bit && EXT_SET_EN_IN && (file_adr <= INDEX_LIMIT);
    wire [11:0] idx_addr = INDEX_BASE_IN + {4'h0, file_adr};
    wire [11:0] acc_addr = (file_adr < ACCESS_SPLIT) ? {4'h0, file_adr}
                                                     : {ACCESS_SFR_BANK, file_adr};
    wire [11:0] bank_addr = {BANK_POINTER_REG_IN, file_adr};
    wire [11:0] eff_addr = acc_bit ? bank_addr : (use_index ? idx_addr : acc_addr);

    // Offset sign extended and doubled so the target stays word aligned.
    wire signed [OFS_W-1:0] ofs = instr_r[OFS_W-1:0];
    wire ofs_sign = ofs[OFS_W-1];
    wire [PC_W-1:0] ofs_x2 = {{(PC_W-OFS_W-1){ofs_sign}}, ofs, 1'h0};
    wire [PC_W-1:0] jump_target = PC_INCR_IN + ofs_x2;

    // ----------------------------------------------------------------
    // Phase and cycle qualifiers
    // ----------------------------------------------------------------
    wire in_q2 = (phase_r == PH_Q2);
    wire in_q3 = (phase_r == PH_Q3);
    wire in_q4 = (phase_r == PH_Q4);
    wire in_exec = (cyc_r == CYC_EXEC);
    wire held_jump = (instr_r[15:12] == OPC_JUMP_NIB) && !instr_r[11];
    wire jump_q4 = in_exec && !bit_op_r && in_q4 && held_jump;
    wire read_strobe = bit_op_r && in_q2;
    wire modify_strobe = bit_op_r && in_q3;
    wire write_strobe = bit_op_r && in_q4;

    // Opcodes that this block does not execute are held with a cleared top
    // nibble, so that no later phase can decode them as a jump or a bit-set.
    wire keep_word = is_jump || is_bitset;
    wire [3:0] class_nib = keep_word ? INSTR_IN[15:12] : 4'h0;
    wire [15:0] instr_take = {class_nib, INSTR_IN[11:0]};

    // ----------------------------------------------------------------
    // Bit lanes of the read, modify and write path
    // ----------------------------------------------------------------
    // Each lane passes its read bit through unless it is the chosen one,
    // so the other seven bits go back exactly as they were read.
    wire [2:0] held_bit = instr_r[11:9];
    wire [7:0] set_data;
    genvar lane;
    generate
        for (lane = 0; lane < 8; lane++)
        begin : g_lane
            assign set_data[lane] = data_r[lane] | (held_bit == 3'(lane));
        end
    endgenerate

    // ----------------------------------------------------------------
    // Phase counter
    // ----------------------------------------------------------------
    // The counter wraps from Q4 to Q1 by itself, so one instruction cycle
    // is always exactly four clocks long.
    always_ff @(posedge CLK_SYS_IN)
    begin
        if (RST_IN)
        begin
            phase_r <= PH_Q1;
        end
        else
        begin
            phase_r <= phase_r + 2'h1;
        end
    end

    // A jump turns the next cycle into a flush, in which nothing is taken.
    always_ff @(posedge CLK_SYS_IN)
    begin
        if (RST_IN)
        begin
            cyc_r <= CYC_EXEC;
        end
        else if (in_q4)
        begin
            cyc_r <= jump_q4 ? CYC_FLUSH : CYC_EXEC;
        end
    end

    // ----------------------------------------------------------------
    // Instruction hold
    // ----------------------------------------------------------------
    always_ff @(posedge CLK_SYS_IN)
    begin
        if (RST_IN)
        begin
            instr_r <= 16'h0000;
        end
        else if (start)
        begin
            instr_r <= instr_take;
        end
        else if (in_q4 && !jump_q4)
        begin
            instr_r <= 16'h0000;
        end
    end

    always_ff @(posedge CLK_SYS_IN)
    begin
        if (RST_IN)
        begin
            addr_r <= 12'h000;
        end
        else if (start)
        begin
            addr_r <= eff_addr;
        end
    end

    always_ff @(posedge CLK_SYS_IN)
    begin
        if (RST_IN)
        begin
            bit_op_r <= 1'h0;
        end
        else if (start)
        begin
            bit_op_r <= is_bitset;
        end
        else if (in_q4)
        begin
            bit_op_r <= 1'h0;
        end
    end

    // ----------------------------------------------------------------
    // Read, modify and write of the addressed register
    // ----------------------------------------------------------------
    always_ff @(posedge CLK_SYS_IN)
    begin
        if (RST_IN)
        begin
            data_r <= 8'h00;
        end
        else if (read_strobe)
        begin
            data_r <= MEM_RDATA_IN;
        end
    end

    always_ff @(posedge CLK_SYS_IN)
    begin
        if (RST_IN)
        begin
            MEM_WDATA_OUT <= 8'h00;
        end
        else if (modify_strobe)
        begin
            MEM_WDATA_OUT <= set_data;
        end
    end

    always_ff @(posedge CLK_SYS_IN)
    begin
        if (RST_IN)
        begin
            PC_NEW_OUT <= {PC_W{1'h0}};
        end
        else if (jump_q4)
        begin
            PC_NEW_OUT <= jump_target;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign PHASE_OUT = phase_r;
    assign MEM_ADDR_OUT = addr_r;
    assign MEM_RD_OUT = read_strobe;
    assign MEM_WR_OUT = write_strobe;
    assign PC_LOAD_OUT = jump_q4;
    assign FLUSH_OUT = (cyc_r == CYC_FLUSH);
    // Neither instruction alters the status flags.
    assign STATUS_WR_OUT = 1'h0;
endmodule : branch_bitset_exec
`default_nettype wire

// ==== branch_bitset_pkg.sv ====
`default_nettype none
package branch_bitset_pkg;
    localparam int PC_W = 21;
    localparam logic [3:0] OPC_JUMP_NIB = 4'hD;
    localparam logic [3:0] OPC_BITSET_NIB = 4'h8;
    localparam int OFS_W = 11;
    localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
    localparam logic [7:0] ACCESS_SPLIT = 8'h60;
    localparam logic [7:0] INDEX_LIMIT = 8'h5F;
    localparam logic [3:0] ACCESS_SFR_BANK = 4'hF;
    localparam logic [1:0] PH_Q1 = 2'h0;
    localparam logic [1:0] PH_Q2 = 2'h1;
    localparam logic [1:0] PH_Q3 = 2'h2;
    localparam logic [1:0] PH_Q4 = 2'h3;
    typedef enum logic [1:0]
    {
        CYC_EXEC = 2'h1,
        CYC_FLUSH = 2'h2
    } cyc_t;
endpackage : branch_bitset_pkg
`default_nettype wire
